// >>> hw/mbx_boot_engine.sv
// boot download handshake engine behind the mailbox exchange region
`include "mbx_cfg.svh"
`default_nettype none
// How it works
// - after reset all mailboxes cleared, then host command box is polled.
// - download ready seen: acknowledge code goes into device command box.
// - byte AA written at window offset 3D causes a full reset.
// - mailboxes 2..5 read as master setup only for download ready.
// - acknowledge consumed by host: device posts download request.
// - write block with valid load address and last byte: copy count bytes, then ack.
// - write block with invalid load address: skip copy, post nak.
// - ack or nak consumed: device posts a fresh download request; an init ack calls first.
// - init procedure: valid address acknowledged, invalid one naked.
// - after ack, wait for host read of device box, then call.
// - called routine returns: post download request, resume commands.
// - host codes are 10 ready, 04 write block, 08 init.
// - device codes are 80 request, 04 ack, 10 nak.
// - reader zeroes a command box; nobody writes a command box until it is zero.
// - count big-endian in boxes 2..3, addresses in 4..7 and 8..11.
module mbx_boot_engine (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic selftest_done_i,
  // host slave window
  input wire mbx_pkg::mbx_slave_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  output logic host_ready_o,
  // byte copy engine and subroutine call
  output mbx_pkg::mbx_copy_req_t copy_req_o,
  input wire logic copy_ack_i,
  output logic [31:0] call_addr_o,
  output logic call_o,
  input wire logic call_return_i,
  // bus master setup
  output mbx_pkg::mbx_master_cfg_t master_cfg_o,
  output logic master_cfg_valid_o
);
  logic [1:0] rst_sync;
  // both resets leave through the synchroniser, never straight off a pin
  wire rst_n = rst_sync[1];
  mbx_pkg::mbx_state_t state;
  logic [7:0] box [`MBX_NUM_BOXES];
  logic [15:0] remain;
  logic [31:0] src;
  logic [31:0] dst;
  logic [7:0] post_code;
  logic dev_clr_hcmd;
  logic dev_set_dcmd;
  logic hcmd_was_init;

  function automatic logic ram_ok(input logic [31:0] a);
    ram_ok = (a >= `MBX_RAM_BASE) && (a < `MBX_RAM_LIMIT);
  endfunction : ram_ok

  wire box_hit = host_req_i.addr < 9'(`MBX_NUM_BOXES);
  wire [3:0] box_idx = host_req_i.addr[3:0];
  wire soft_hit = host_req_i.wr && host_req_i.addr == `MBX_OFS_SOFT_RESET
    && host_req_i.wdata == `MBX_SOFT_RESET_KEY;
  wire host_wr_box = host_req_i.wr && box_hit;
  wire [7:0] hcmd = box[`MBX_BOX_HCMD];
  wire [31:0] load_addr = {box[4], box[5], box[6], box[7]};
  wire [31:0] host_addr = {box[8], box[9], box[10], box[11]};
  wire [15:0] byte_cnt = {box[2], box[3]};
  // the whole block must fit: the last byte is checked, not one past it
  wire [31:0] last_addr = load_addr + 32'(byte_cnt) - 32'h1;
  // a box is free for posting only after the host has zeroed it
  wire dcmd_free = box[`MBX_BOX_DCMD] == 8'h00;

  // the key write empties the synchroniser: a full reset of about two
  // cycles that releases on a clock edge like the power-on one
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else if (soft_hit) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MBX_NUM_BOXES; g++) begin : g_box
      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          box[g] <= 8'h00;
        end else if (g == 1 && dev_set_dcmd) begin
          box[g] <= post_code;
        end else if (g == 0 && dev_clr_hcmd) begin
          box[g] <= 8'h00;
        end else if (host_wr_box && box_idx == 4'(g)) begin
          box[g] <= host_req_i.wdata;
        end
      end
    end
  endgenerate

  // device wins a same-cycle race so a posted code is never lost
  assign dev_clr_hcmd = state == mbx_pkg::MBX_ST_POLL && hcmd != 8'h00;
  assign dev_set_dcmd = state == mbx_pkg::MBX_ST_POST && dcmd_free;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= mbx_pkg::MBX_ST_INIT;
      post_code <= 8'h00;
      remain <= 16'h0000;
      src <= 32'h0;
      dst <= 32'h0;
      call_o <= 1'b0;
      call_addr_o <= 32'h0;
      master_cfg_o <= '0;
      master_cfg_valid_o <= 1'b0;
      copy_req_o <= '0;
    end else begin
      call_o <= 1'b0;
      case (state)
        mbx_pkg::MBX_ST_INIT: begin
          if (selftest_done_i) begin
            state <= mbx_pkg::MBX_ST_POLL;
          end
        end
        mbx_pkg::MBX_ST_POLL: begin
          if (hcmd == `MBX_HC_DL_READY) begin
            master_cfg_o <= {box[`MBX_BOX_VEC], box[`MBX_BOX_LEV],
              box[`MBX_BOX_MODE], box[`MBX_BOX_AMOD]};
            master_cfg_valid_o <= 1'b1;
            post_code <= `MBX_DC_ACK;
            state <= mbx_pkg::MBX_ST_POST;
          end else if (hcmd == `MBX_HC_WR_BLOCK) begin
            if (ram_ok(load_addr) && (byte_cnt == 16'h0000
                || ram_ok(last_addr))) begin
              remain <= byte_cnt;
              src <= host_addr;
              dst <= load_addr;
              state <= mbx_pkg::MBX_ST_COPY;
            end else begin
              post_code <= `MBX_DC_NAK;
              state <= mbx_pkg::MBX_ST_POST;
            end
          end else if (hcmd == `MBX_HC_INIT_PROC) begin
            call_addr_o <= load_addr;
            post_code <= ram_ok(load_addr) ? `MBX_DC_ACK
              : `MBX_DC_NAK;
            state <= mbx_pkg::MBX_ST_POST;
          end else if (hcmd != 8'h00) begin
            // unknown command: consumed and refused
            post_code <= `MBX_DC_NAK;
            state <= mbx_pkg::MBX_ST_POST;
          end
        end
        mbx_pkg::MBX_ST_COPY: begin
          if (remain == 16'h0000) begin
            copy_req_o.valid <= 1'b0;
            post_code <= `MBX_DC_ACK;
            state <= mbx_pkg::MBX_ST_POST;
          end else if (copy_req_o.valid && copy_ack_i) begin
            copy_req_o.valid <= 1'b0;
            remain <= remain - 16'h0001;
            src <= src + 32'h1;
            dst <= dst + 32'h1;
          end else begin
            copy_req_o <= '{valid: 1'b1, src: src, dst: dst};
          end
        end
        mbx_pkg::MBX_ST_POST: begin
          if (dcmd_free) begin
            // every answer but a request waits for the host to take it
            if (post_code == `MBX_DC_DL_REQ) begin
              state <= mbx_pkg::MBX_ST_POLL;
            end else begin
              state <= mbx_pkg::MBX_ST_WAIT_READ;
            end
          end
        end
        mbx_pkg::MBX_ST_WAIT_READ: begin
          // host has read and zeroed the answer
          if (dcmd_free) begin
            if (hcmd_was_init && post_code == `MBX_DC_ACK) begin
              call_o <= 1'b1;
              state <= mbx_pkg::MBX_ST_CALL;
            end else begin
              post_code <= `MBX_DC_DL_REQ;
              state <= mbx_pkg::MBX_ST_POST;
            end
          end
        end
        mbx_pkg::MBX_ST_CALL: begin
          if (call_return_i) begin
            post_code <= `MBX_DC_DL_REQ;
            state <= mbx_pkg::MBX_ST_POST;
          end
        end
        default: state <= mbx_pkg::MBX_ST_INIT;
      endcase
    end
  end

  // remembers that the command being answered is init procedure
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hcmd_was_init <= 1'b0;
    end else if (dev_clr_hcmd) begin
      hcmd_was_init <= hcmd == `MBX_HC_INIT_PROC;
    end
  end

  // reads return the box one cycle later; reset key register reads zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_o <= 8'h00;
      host_ready_o <= 1'b0;
    end else begin
      host_ready_o <= host_req_i.rd | host_req_i.wr;
      host_rdata_o <= (host_req_i.rd && box_hit) ? box[box_idx] : 8'h00;
    end
  end

endmodule : mbx_boot_engine
`default_nettype wire

// >>> hw/mbx_cfg.svh
// constants for the mailbox boot download handshake engine
`ifndef MBX_CFG_SVH
`define MBX_CFG_SVH
`define MBX_WIN_AW 9
`define MBX_OFS_SOFT_RESET 9'h03D
`define MBX_SOFT_RESET_KEY 8'hAA
`define MBX_NUM_BOXES 16
`define MBX_BOX_HCMD 4'h0
`define MBX_BOX_DCMD 4'h1
`define MBX_BOX_VEC 4'h2
`define MBX_BOX_LEV 4'h3
`define MBX_BOX_MODE 4'h4
`define MBX_BOX_AMOD 4'h5
`define MBX_BOX_CNT_HI 4'h2
`define MBX_BOX_LOAD0 4'h4
`define MBX_BOX_HOST0 4'h8
`define MBX_HC_DL_READY 8'h10
`define MBX_HC_WR_BLOCK 8'h04
`define MBX_HC_INIT_PROC 8'h08
`define MBX_DC_DL_REQ 8'h80
`define MBX_DC_ACK 8'h04
`define MBX_DC_NAK 8'h10
`define MBX_RAM_BASE 32'h0000_0000
`define MBX_RAM_LIMIT 32'h0040_0000
`endif

// >>> hw/mbx_pkg.sv
// types for the mailbox boot download handshake engine
`default_nettype none
package mbx_pkg;
  typedef enum logic [2:0] {
    MBX_ST_INIT, MBX_ST_POLL, MBX_ST_COPY, MBX_ST_CALL, MBX_ST_WAIT_READ,
    MBX_ST_POST
  } mbx_state_t;
  // slave window access from the host
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } mbx_slave_req_t;
  // byte copy request towards host memory and local ram
  typedef struct packed {
    logic valid;
    logic [31:0] src;
    logic [31:0] dst;
  } mbx_copy_req_t;
  // bus master setup captured from download ready
  typedef struct packed {
    logic [7:0] vec;
    logic [7:0] lev;
    logic [7:0] mode;
    logic [7:0] amod;
  } mbx_master_cfg_t;
endpackage : mbx_pkg
`default_nettype wire

// >>> verif/mbx_boot_monitor.sv
// port assertions for the boot download handshake engine
`include "mbx_cfg.svh"
`default_nettype none
module mbx_boot_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic selftest_done_i,
  // host window
  input wire mbx_pkg::mbx_slave_req_t host_req_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_ready_o,
  // copy and call
  input wire mbx_pkg::mbx_copy_req_t copy_req_o,
  input wire logic copy_ack_i,
  input wire logic [31:0] call_addr_o,
  input wire logic call_o,
  input wire logic call_return_i,
  // master setup
  input wire mbx_pkg::mbx_master_cfg_t master_cfg_o,
  input wire logic master_cfg_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_wait;
    copy_req_o.valid && !copy_ack_i;
  endsequence
  sequence s_done;
    copy_req_o.valid && copy_ack_i;
  endsequence
  a_ready_has_req: assert property (
    host_ready_o |-> $past(host_req_i.rd || host_req_i.wr))
    else $error("ready without access");
  a_idle_no_ready: assert property (
    !(host_req_i.rd || host_req_i.wr) |=> !host_ready_o)
    else $error("ready while idle");
  a_copy_held: assert property (
    s_wait |=> copy_req_o.valid && $stable(copy_req_o))
    else $error("copy request moved");
  a_copy_drops: assert property (
    s_done |=> !copy_req_o.valid)
    else $error("copy request kept after ack");
  a_copy_in_ram: assert property (
    copy_req_o.valid |-> copy_req_o.dst < `MBX_RAM_LIMIT)
    else $error("copy outside ram");
  a_copy_after_setup: assert property (
    $rose(copy_req_o.valid) |-> master_cfg_valid_o)
    else $error("copy before setup");
  a_call_in_ram: assert property (
    call_o |-> call_addr_o < `MBX_RAM_LIMIT)
    else $error("call outside ram");
  a_call_single: assert property (
    call_o |=> !call_o)
    else $error("call longer than a pulse");
  a_call_no_copy: assert property (
    call_o |-> !copy_req_o.valid && master_cfg_valid_o)
    else $error("call during copy");
endmodule : mbx_boot_monitor
bind mbx_boot_engine mbx_boot_monitor mon (.clk_i, .rstn_i, .selftest_done_i,
  .host_req_i, .host_rdata_o, .host_ready_o, .copy_req_o, .copy_ack_i,
  .call_addr_o, .call_o, .call_return_i, .master_cfg_o, .master_cfg_valid_o);
`default_nettype wire

// >>> verif/mbx_far_model.sv
// copy engine and called routine facing the boot engine
`default_nettype none
module mbx_far_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // bench control
  input wire logic slow_i,
  input wire logic clr_i,
  // engine side
  input wire mbx_pkg::mbx_copy_req_t copy_req_i,
  output logic copy_ack_o,
  input wire logic call_i,
  output logic call_return_o,
  // observation
  output logic [15:0] n_copied_o,
  output logic [31:0] first_dst_o,
  output logic [31:0] last_src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  // slow mode holds each byte a few cycles, as a busy bus would
  wire logic take = copy_req_i.valid && !copy_ack_o;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_cnt <= 3'h0;
      copy_ack_o <= 1'b0;
      call_return_o <= 1'b0;
      n_copied_o <= 16'h0000;
      first_dst_o <= 32'h0;
      last_src_o <= 32'h0;
    end else begin
      copy_ack_o <= take && wait_cnt >= (slow_i ? 3'h3 : 3'h0);
      wait_cnt <= take ? wait_cnt + 3'h1 : 3'h0;
      call_return_o <= call_i;
      if (clr_i) n_copied_o <= 16'h0000;
      else if (copy_ack_o) n_copied_o <= n_copied_o + 16'h0001;
      if (copy_ack_o && n_copied_o == 16'h0000) first_dst_o <= copy_req_i.dst;
      if (copy_ack_o) last_src_o <= copy_req_i.src;
    end
  end
endmodule : mbx_far_model
`default_nettype wire

// >>> verif/mailbox_boot_download_handshake_tb.sv
// self-checking bench for the boot download handshake engine
`include "mbx_cfg.svh"
`default_nettype none
module mailbox_boot_download_handshake_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rstn_i = 0, selftest_done_i = 0, slow = 0, clr = 0;
  mbx_pkg::mbx_slave_req_t host_req_i = '0;
  mbx_pkg::mbx_copy_req_t copy_req_o;
  mbx_pkg::mbx_master_cfg_t master_cfg_o;
  logic [7:0] host_rdata_o;
  logic host_ready_o, copy_ack_i, call_o, call_return_i, master_cfg_valid_o;
  logic [31:0] call_addr_o, f_dst, l_src, call_at, cfg_v;
  logic [15:0] n_cp;
  logic call_seen = 0;
  int n_mismatch = 0, samples_checked = 0;
  mbx_boot_engine dut (.clk_i, .rstn_i, .selftest_done_i, .host_req_i,
    .host_rdata_o, .host_ready_o, .copy_req_o, .copy_ack_i, .call_addr_o,
    .call_o, .call_return_i, .master_cfg_o, .master_cfg_valid_o);
  mbx_far_model far (.clk_i, .rstn_i, .slow_i(slow), .clr_i(clr),
    .copy_req_i(copy_req_o), .copy_ack_o(copy_ack_i), .call_i(call_o),
    .call_return_o(call_return_i), .n_copied_o(n_cp), .first_dst_o(f_dst),
    .last_src_o(l_src));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (call_o === 1'b1) begin
    call_seen <= 1'b1;
    call_at <= call_addr_o;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one-cycle strobe; the answer stands in the cycle after the taking edge
  task acc(input logic w, input logic [8:0] a, input logic [7:0] d,
           output logic [7:0] q, output logic r);
    @(posedge clk_i);
    #1 host_req_i = {~w, w, a, d};
    @(posedge clk_i);
    #1 host_req_i = '0;
    q = host_rdata_o;
    r = host_ready_o;
  endtask : acc
  task wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic r;
    acc(1'b1, a, d, q, r);
    chk("write ready", 1, 32'(r));
  endtask : wr
  task poll(input logic [7:0] e);
    logic [7:0] q;
    logic r;
    q = 0;
    for (int i = 0; i < 300 && q == 0; i++) acc(1'b0, 9'h001, 8'h00, q, r);
    chk("device box", 32'(e), 32'(q));
    wr(9'h001, 8'h00);
  endtask : poll
  function logic [7:0] want(input logic [7:0] c, input logic [15:0] n,
                            input logic [31:0] ld);
    if (c == `MBX_HC_WR_BLOCK && ld < `MBX_RAM_LIMIT
        && ld + n <= `MBX_RAM_LIMIT) return `MBX_DC_ACK;
    if (c == `MBX_HC_INIT_PROC && ld < `MBX_RAM_LIMIT) return `MBX_DC_ACK;
    return `MBX_DC_NAK;
  endfunction : want
  task boot;
    logic [7:0] q;
    logic r;
    logic [31:0] v;
    r = 0;
    for (int i = 0; i < 20 && r !== 1'b1; i++) acc(1'b0, 9'h000, 8'h00, q, r);
    chk("probe ready", 1, 32'(r));
    chk("cfg valid", 0, 32'(master_cfg_valid_o));
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 9'(i), 8'h00, q, r);
      chk("cleared box", 0, 32'(q));
    end
    v = $urandom();
    cfg_v = v;
    for (int i = 0; i < 4; i++) wr(9'(2 + i), v[31 - 8 * i -: 8]);
    wr(9'h000, `MBX_HC_DL_READY);
    poll(`MBX_DC_ACK);
    acc(1'b0, 9'h000, 8'h00, q, r);
    chk("host box", 0, 32'(q));
    chk("setup", v, master_cfg_o);
    chk("cfg valid", 1, 32'(master_cfg_valid_o));
    poll(`MBX_DC_DL_REQ);
  endtask : boot
  task cmd(input logic [7:0] c, input logic [15:0] n, input logic [31:0] ld,
           input logic [31:0] hs);
    logic [79:0] f;
    logic [7:0] e;
    logic blk;
    logic inv;
    f = {n, ld, hs};
    e = want(c, n, ld);
    blk = c == `MBX_HC_WR_BLOCK && e == `MBX_DC_ACK;
    inv = c == `MBX_HC_INIT_PROC && e == `MBX_DC_ACK;
    @(posedge clk_i);
    #1 clr = 1;
    call_seen = 0;
    @(posedge clk_i);
    #1 clr = 0;
    for (int i = 0; i < 10; i++) wr(9'(2 + i), f[79 - 8 * i -: 8]);
    wr(9'h000, c);
    poll(e);
    poll(`MBX_DC_DL_REQ);
    chk("bytes", blk ? n : 16'h0000, n_cp);
    if (blk) begin
      chk("first dst", ld, f_dst);
      chk("last src", hs + n - 1, l_src);
    end
    chk("called", 32'(inv), 32'(call_seen));
    if (call_seen === 1'b1) chk("call addr", ld, call_at);
    chk("setup kept", cfg_v, master_cfg_o);
  endtask : cmd
  task results;
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  initial begin
    logic [7:0] q;
    logic r;
    void'($urandom(32'h6074f6f8));
    repeat (2) @(posedge clk_i);
    #1 rstn_i = 1;
    selftest_done_i = 1;
    boot();
    cmd(`MBX_HC_WR_BLOCK, 16'h0001, `MBX_RAM_LIMIT - 1,
        32'h0000_1000);
    cmd(`MBX_HC_WR_BLOCK, 16'h0002, `MBX_RAM_LIMIT - 1,
        32'h0000_2000);
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      cmd(`MBX_HC_WR_BLOCK, 16'(1 + $urandom_range(7)),
          $urandom_range(32'h003F_0000), $urandom());
    end
    cmd(8'h55, 16'h0001, 32'h0000_0000, 32'h0000_0000);
    cmd(`MBX_HC_INIT_PROC, 16'($urandom()), `MBX_RAM_LIMIT,
        $urandom());
    cmd(`MBX_HC_INIT_PROC, 16'h0000, 32'h0000_0000, 32'h0000_0000);
    cmd(`MBX_HC_INIT_PROC, 16'($urandom()), $urandom_range(32'h003F_FFFF),
        $urandom());
    acc(1'b1, `MBX_OFS_SOFT_RESET, `MBX_SOFT_RESET_KEY, q, r);
    boot();
    results();
  end
endmodule : mailbox_boot_download_handshake_tb
`default_nettype wire
